// File: include/bio_regs.vh
// register map, field positions and reset values of the bidirectional i/o port
`ifndef BIO_REGS_VH
`define BIO_REGS_VH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define BIO_NUM_PORTS 3
`define BIO_PORT_W 8
`define BIO_PINS 24
`define BIO_ADDR_W 8
`define BIO_DATA_W 32

// ----------------------------------------------------------------------------
// address decode: a[7] selects control, a[6:5] the port, a[4:0] the register
// ----------------------------------------------------------------------------
`define BIO_AREA_BIT 7
`define BIO_PORT_HI 6
`define BIO_PORT_LO 5
`define BIO_OFF_HI 4
`define BIO_OFF_LO 0
`define BIO_LAST_PORT 2'h2
`define BIO_ONE_PORT 3'h1
`define BIO_NO_PORT 3'h0
`define BIO_LANE_LOW 0

// ----------------------------------------------------------------------------
// register offsets inside one port
// ----------------------------------------------------------------------------
`define BIO_OFF_PIN 5'h00
`define BIO_OFF_DIR 5'h04
`define BIO_OFF_OUT 5'h08
`define BIO_OFF_DIR_SET 5'h0c
`define BIO_OFF_DIR_CLR 5'h10
`define BIO_OFF_OUT_SET 5'h14
`define BIO_OFF_OUT_CLR 5'h18

// ----------------------------------------------------------------------------
// mcu control register
// ----------------------------------------------------------------------------
`define BIO_ADDR_CTRL 8'h80
`define BIO_PUD_BIT 4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define BIO_RST_DIR 24'h000000
`define BIO_RST_OUT 24'h000000
`define BIO_RST_PUD 1'h0
`define BIO_RST_RDATA 32'h00000000
`define BIO_ZERO_BYTE 8'h00
`define BIO_ZERO_HI 24'h000000
`define BIO_RST_WAIT 1'h1
`define BIO_RST_OE_N 1'h1
`define BIO_RST_BIT 1'h0

`endif

// File: core/bio_pin_cell.v
// one pin: pad drive, pull-up control and input synchroniser
`timescale 1ns/1ps
`include "bio_regs.vh"

module bio_pin_cell (
   input wire clk,
   input wire rst_n,
   input wire pinDirectionBit,
   input wire pinOutputValueBit,
   input wire globalPullupDisable,
   input wire altOwn,
   input wire altDrive,
   input wire altValue,
   input wire padIn,
   output reg padOut,
   output reg padOe_n,
   output reg pullupEn,
   output reg pinInputBit
);

   // -------------------------------------------------------------------------
   // pad drive and pull-up
   // -------------------------------------------------------------------------
   wire driveEn;
   wire driveVal;
   wire pullWant;
   reg syncLow_q;

   assign driveEn = altOwn ? altDrive : pinDirectionBit; // see RULE1 see RULE16
   assign driveVal = altOwn ? altValue : pinOutputValueBit; // see RULE4
   assign pullWant = !altOwn && !pinDirectionBit && pinOutputValueBit
      && !globalPullupDisable; // see RULE2 see RULE6 see RULE17

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         padOe_n <= `BIO_RST_OE_N; // see RULE3
         padOut <= `BIO_RST_BIT;
         pullupEn <= `BIO_RST_BIT;
      end else begin
         padOe_n <= !driveEn;
         padOut <= driveVal;
         pullupEn <= pullWant;
      end
   end

   // -------------------------------------------------------------------------
   // synchroniser: falling-edge capture, then rising-edge register
   // -------------------------------------------------------------------------
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncLow_q <= `BIO_RST_BIT;
      end else begin
         syncLow_q <= padIn; // see RULE11
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinInputBit <= `BIO_RST_BIT;
      end else begin
         pinInputBit <= syncLow_q; // see RULE11 see RULE10 see RULE12
      end
   end

endmodule // bio_pin_cell

// File: core/bio_port.v
// three eight-bit general purpose i/o ports behind an avalon-mm slave
//
// How it works
// RULE1: direction bit one drives, zero is input
// RULE2: input with output bit one enables pull-up
// RULE3: reset tri-states every pin without a clock
// RULE4: output pins follow the output-value bit
// RULE5: writing one to input bit toggles output
// RULE6: global pull-up disable turns all pull-ups off
// RULE7: direction and output bits reset to zero
// RULE8: tri-state to high passes an intermediate state
// RULE9: pull-up to output low passes intermediate state
// RULE10: input bit reads pin level in any direction
// RULE11: falling-edge latch, rising-edge input register
// RULE12: written output readable one clock later; here the pin input bit follows two clocks after out_q updates
// RULE13: bit set or clear touches one pin only; here one write sets or clears every pin whose write-data bit is one
// RULE14: output, direction read-write; pin input read-only
// RULE15: strobes per port, pull-up disable shared
// RULE16: alternate pins leave other pins as gpio
// RULE17: pull-up disable overrides direction zero, output one
// RULE18: eight bits per register, bit n is pin n
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "bio_regs.vh"

module bio_port (
   input wire clk,
   input wire rst_n,
   input wire [`BIO_ADDR_W-1:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [`BIO_DATA_W-1:0] avsWritedata,
   input wire [3:0] avsByteenable,
   output reg [`BIO_DATA_W-1:0] avsReaddata,
   output reg avsWaitrequest,
   input wire [`BIO_PINS-1:0] padIn,
   output wire [`BIO_PINS-1:0] padOut,
   output wire [`BIO_PINS-1:0] padOe_n,
   output wire [`BIO_PINS-1:0] pullupEn,
   input wire [`BIO_PINS-1:0] altOwn,
   input wire [`BIO_PINS-1:0] altDrive,
   input wire [`BIO_PINS-1:0] altValue
);

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   // register images and their next values
   reg [`BIO_PINS-1:0] dir_q;
   wire [`BIO_PINS-1:0] dir_d;
   reg [`BIO_PINS-1:0] out_q;
   wire [`BIO_PINS-1:0] out_d;
   reg pud_q;
   reg pud_d;
   reg bus_q;
   reg bus_d;
   // read path
   reg [`BIO_DATA_W-1:0] rdata_d;
   reg [`BIO_PORT_W-1:0] rdByte;
   wire [`BIO_PINS-1:0] readBytes;
   wire [`BIO_PINS-1:0] pinIn;
   integer i;

   // bus handshake states: idle waits for a request, answer lowers waitrequest
   localparam BUS_IDLE = 1'h0;
   localparam BUS_ANSWER = 1'h1;

   // -------------------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------------------
   wire ctrlHit;
   wire portArea;
   wire [1:0] portIdx;
   wire portHit;
   wire [`BIO_NUM_PORTS-1:0] portSel;
   wire [4:0] regOff;
   wire laneOk;
   wire doWrite;
   wire doRead;

   assign ctrlHit = (avsAddress == `BIO_ADDR_CTRL);
   assign portArea = !avsAddress[`BIO_AREA_BIT];
   assign portIdx = avsAddress[`BIO_PORT_HI:`BIO_PORT_LO];
   assign portHit = portArea && (portIdx <= `BIO_LAST_PORT); // see RULE15
   assign portSel = portHit ? (`BIO_ONE_PORT << portIdx) : `BIO_NO_PORT;
   assign regOff = avsAddress[`BIO_OFF_HI:`BIO_OFF_LO];
   assign laneOk = avsByteenable[`BIO_LANE_LOW];
   assign doWrite = avsWrite && !avsWaitrequest && laneOk;
   assign doRead = avsRead && avsWaitrequest;

   // -------------------------------------------------------------------------
   // register offset decode inside a port
   // -------------------------------------------------------------------------
   wire offPin;
   wire offDir;
   wire offOut;
   wire offDirSet;
   wire offDirClr;
   wire offOutSet;
   wire offOutClr;

   assign offPin = (regOff == `BIO_OFF_PIN);
   assign offDir = (regOff == `BIO_OFF_DIR);
   assign offOut = (regOff == `BIO_OFF_OUT);
   assign offDirSet = (regOff == `BIO_OFF_DIR_SET);
   assign offDirClr = (regOff == `BIO_OFF_DIR_CLR);
   assign offOutSet = (regOff == `BIO_OFF_OUT_SET);
   assign offOutClr = (regOff == `BIO_OFF_OUT_CLR);

   // -------------------------------------------------------------------------
   // per-port strobes, shared by the eight pins of each port
   // -------------------------------------------------------------------------
   // write strobes
   wire [`BIO_NUM_PORTS-1:0] inputRegWriteStrobe;
   wire [`BIO_NUM_PORTS-1:0] directionRegWriteStrobe;
   wire [`BIO_NUM_PORTS-1:0] outputRegWriteStrobe;
   wire [`BIO_NUM_PORTS-1:0] dirSetStrobe;
   wire [`BIO_NUM_PORTS-1:0] dirClrStrobe;
   wire [`BIO_NUM_PORTS-1:0] outSetStrobe;
   wire [`BIO_NUM_PORTS-1:0] outClrStrobe;

   // read strobes
   wire [`BIO_NUM_PORTS-1:0] pinReadStrobe;
   wire [`BIO_NUM_PORTS-1:0] directionRegReadStrobe;
   wire [`BIO_NUM_PORTS-1:0] outputRegReadStrobe;

   genvar p;
   generate
      for (p = 0; p < `BIO_NUM_PORTS; p = p + 1) begin : gStrobe
         wire wrHere;
         wire rdHere;

         assign wrHere = doWrite && portSel[p]; // see RULE15
         assign rdHere = doRead && portSel[p]; // see RULE15

         // write strobes
         assign inputRegWriteStrobe[p] = wrHere && offPin;
         assign directionRegWriteStrobe[p] = wrHere && offDir;
         assign outputRegWriteStrobe[p] = wrHere && offOut;
         assign dirSetStrobe[p] = wrHere && offDirSet;
         assign dirClrStrobe[p] = wrHere && offDirClr;
         assign outSetStrobe[p] = wrHere && offOutSet;
         assign outClrStrobe[p] = wrHere && offOutClr;

         // read strobes
         assign pinReadStrobe[p] = rdHere && offPin;
         assign directionRegReadStrobe[p] = rdHere && offDir;
         assign outputRegReadStrobe[p] = rdHere && offOut;
      end
   endgenerate

   // -------------------------------------------------------------------------
   // direction register: next value per port
   // -------------------------------------------------------------------------
   wire [`BIO_PORT_W-1:0] wByte;

   assign wByte = avsWritedata[`BIO_PORT_W-1:0];

   generate
      for (p = 0; p < `BIO_NUM_PORTS; p = p + 1) begin : gDir
         wire [`BIO_PORT_W-1:0] dirNow;
         reg [`BIO_PORT_W-1:0] dirNext;

         assign dirNow = dir_q[p*`BIO_PORT_W +: `BIO_PORT_W]; // see RULE18

         always @* begin
            dirNext = dirNow;
            if (directionRegWriteStrobe[p]) begin
               dirNext = wByte; // see RULE1 see RULE14
            end
            if (dirSetStrobe[p]) begin
               dirNext = dirNow | wByte; // see RULE13
            end
            if (dirClrStrobe[p]) begin
               dirNext = dirNow & ~wByte; // see RULE13
            end
         end

         assign dir_d[p*`BIO_PORT_W +: `BIO_PORT_W] = dirNext;
      end
   endgenerate

   // -------------------------------------------------------------------------
   // output value register: next value per port
   // -------------------------------------------------------------------------
   generate
      for (p = 0; p < `BIO_NUM_PORTS; p = p + 1) begin : gOut
         wire [`BIO_PORT_W-1:0] outNow;
         reg [`BIO_PORT_W-1:0] outNext;

         assign outNow = out_q[p*`BIO_PORT_W +: `BIO_PORT_W]; // see RULE18

         always @* begin
            outNext = outNow;
            if (inputRegWriteStrobe[p]) begin
               outNext = outNow ^ wByte; // see RULE5
            end
            if (outputRegWriteStrobe[p]) begin
               outNext = wByte; // see RULE14
            end
            if (outSetStrobe[p]) begin
               outNext = outNow | wByte; // see RULE13
            end
            if (outClrStrobe[p]) begin
               outNext = outNow & ~wByte; // see RULE13
            end
         end

         assign out_d[p*`BIO_PORT_W +: `BIO_PORT_W] = outNext;
      end
   endgenerate

   // -------------------------------------------------------------------------
   // read side: data for the answer
   // -------------------------------------------------------------------------
   generate
      for (p = 0; p < `BIO_NUM_PORTS; p = p + 1) begin : gRead
         reg [`BIO_PORT_W-1:0] readNext;

         always @* begin
            readNext = `BIO_ZERO_BYTE;
            if (pinReadStrobe[p]) begin
               readNext = pinIn[p*`BIO_PORT_W +: `BIO_PORT_W]; // see RULE10
            end else if (directionRegReadStrobe[p]) begin
               readNext = dir_q[p*`BIO_PORT_W +: `BIO_PORT_W];
            end else if (outputRegReadStrobe[p]) begin
               readNext = out_q[p*`BIO_PORT_W +: `BIO_PORT_W];
            end
         end

         assign readBytes[p*`BIO_PORT_W +: `BIO_PORT_W] = readNext;
      end
   endgenerate

   // unaddressed ports give zero, so the bytes can be merged by or
   always @* begin
      rdByte = `BIO_ZERO_BYTE;
      for (i = 0; i < `BIO_NUM_PORTS; i = i + 1) begin
         rdByte = rdByte | readBytes[i*`BIO_PORT_W +: `BIO_PORT_W];
      end
      rdata_d = {`BIO_ZERO_HI, rdByte};
      if (ctrlHit) begin
         rdata_d = `BIO_RST_RDATA;
         rdata_d[`BIO_PUD_BIT] = pud_q;
      end
   end

   // -------------------------------------------------------------------------
   // control register: global pull-up disable
   // -------------------------------------------------------------------------
   always @* begin
      pud_d = pud_q;
      if (doWrite && ctrlHit) begin
         pud_d = avsWritedata[`BIO_PUD_BIT]; // see RULE6
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pud_q <= `BIO_RST_PUD;
      end else begin
         pud_q <= pud_d;
      end
   end

   // -------------------------------------------------------------------------
   // bus handshake
   // -------------------------------------------------------------------------
   // idle to answer on any request; the answer lasts one cycle
   always @* begin
      bus_d = bus_q;
      case (bus_q)
         BUS_IDLE: begin
            if (avsRead || avsWrite) begin
               bus_d = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            bus_d = BUS_IDLE;
         end
         default: begin
            bus_d = BUS_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_q <= BUS_IDLE;
         avsWaitrequest <= `BIO_RST_WAIT;
         avsReaddata <= `BIO_RST_RDATA;
      end else begin
         bus_q <= bus_d;
         avsWaitrequest <= (bus_d == BUS_IDLE);
         if (doRead) begin
            avsReaddata <= rdata_d;
         end
      end
   end

   // -------------------------------------------------------------------------
   // port registers
   // -------------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q <= `BIO_RST_DIR; // see RULE7
         out_q <= `BIO_RST_OUT; // see RULE7
      end else begin
         dir_q <= dir_d;
         out_q <= out_d;
      end
   end

   // -------------------------------------------------------------------------
   // pin cells
   // -------------------------------------------------------------------------
   // one cell per pin; alternate ownership is decided pin by pin
   genvar g;
   generate
      for (g = 0; g < `BIO_PINS; g = g + 1) begin : gPin
         bio_pin_cell uCell (
            .clk(clk),
            .rst_n(rst_n),
            .pinDirectionBit(dir_q[g]),
            .pinOutputValueBit(out_q[g]),
            .globalPullupDisable(pud_q), // see RULE15
            .altOwn(altOwn[g]),
            .altDrive(altDrive[g]),
            .altValue(altValue[g]),
            .padIn(padIn[g]),
            .padOut(padOut[g]),
            .padOe_n(padOe_n[g]),
            .pullupEn(pullupEn[g]),
            .pinInputBit(pinIn[g])
         );
      end
   endgenerate

endmodule // bio_port

// File: verification/bio_port_monitor.sv
// checker for the i/o port bus and pad outputs
`timescale 1ns/1ps
`include "bio_regs.vh"
module bio_port_monitor (
   input logic clk,
   input logic rst_n,
   input logic [7:0] avsAddress,
   input logic avsRead,
   input logic avsWrite,
   input logic [31:0] avsWritedata,
   input logic [3:0] avsByteenable,
   input logic [31:0] avsReaddata,
   input logic avsWaitrequest,
   input logic [23:0] padOut,
   input logic [23:0] padOe_n,
   input logic [23:0] pullupEn,
   input logic [23:0] altOwn
);
   // ------------------------------
   // committed write tracking
   // ------------------------------
   logic hit_q, pud_q;
   logic [4:0] off_q;
   logic [23:0] m_q;
   wire wrDone = avsWrite && !avsWaitrequest && avsByteenable[0];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
         pud_q <= 1'b0;
      end else begin
         hit_q <= wrDone && !avsAddress[7] && avsAddress[6:5] != 2'h3;
         if (wrDone && avsAddress == `BIO_ADDR_CTRL)
            pud_q <= avsWritedata[`BIO_PUD_BIT];
      end
   end
   always @(posedge clk) begin
      if (wrDone) begin
         off_q <= avsAddress[4:0];
         m_q <= 24'(avsWritedata[7:0]) << (8 * avsAddress[6:5]);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   rstTri_a: assert property ($rose(rst_n) |-> &padOe_n && pullupEn == 24'h0)
      else $error("pins not released by reset");
   pullDrv_a: assert property ((pullupEn & ~padOe_n) == 24'h0)
      else $error("pull-up on driven pin");
   pudOff_a: assert property (pud_q && $past(pud_q) |-> pullupEn == 24'h0)
      else $error("pull-up while disabled");
   dirSet_a: assert property (hit_q && off_q == `BIO_OFF_DIR_SET |=>
      (padOe_n & m_q & ~altOwn) == 24'h0) else $error("set pin not driven");
   dirClr_a: assert property (hit_q && off_q == `BIO_OFF_DIR_CLR |=>
      (~padOe_n & m_q & ~altOwn) == 24'h0) else $error("cleared pin still driven");
   outSet_a: assert property (hit_q && off_q == `BIO_OFF_OUT_SET |=>
      (~padOut & ~padOe_n & m_q & ~altOwn) == 24'h0) else $error("driven pin not high");
   hiZero_a: assert property (avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0)
      else $error("upper read bits set");
   ansBound_a: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
      else $error("request not answered");
   cover property (hit_q && off_q == `BIO_OFF_DIR_CLR);
   cover property (pud_q && pullupEn == 24'h0);
   cover property (avsRead && !avsWaitrequest);
endmodule // bio_port_monitor
bind bio_port bio_port_monitor bio_port_monitor_i (.*);

// File: verification/bio_pin_env.sv
// pin environment: outside drivers, pull-ups and floating lines
`timescale 1ns/1ps
module bio_pin_env (
   input logic clk,
   input logic [23:0] padOut,
   input logic [23:0] padOe_n,
   input logic [23:0] pullupEn,
   input logic [23:0] extEn,
   input logic [23:0] extVal,
   output logic [23:0] padIn
);
   logic [23:0] float_q = 24'h000000;
   always @(posedge clk) float_q <= ~float_q;
   // driven pins show their drive, then outside driver, pull-up, noise
   assign padIn = ~padOe_n & padOut | padOe_n & (extEn & extVal | ~extEn & (pullupEn | float_q));
endmodule // bio_pin_env

// File: verification/tb_top.sv
// self-checking testbench for the i/o port
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest;
   logic [7:0] avsAddress = 8'h00;
   logic [3:0] avsByteenable = 4'h0;
   logic [31:0] avsWritedata = 32'h0, avsReaddata, rdv;
   logic [23:0] padIn, padOut, padOe_n, pullupEn, altOwn = 24'h0, altDrive = 24'h0;
   logic [23:0] altValue = 24'h0, extEn = 24'hffffff, extVal = 24'h5a3c81;
   int fails = 0, checks = 0;
   initial forever #2 clk = ~clk;
   bio_port bio_port_i (.*);
   bio_pin_env bio_pin_env_i (.*);
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      int n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWritedata <= d;
      avsByteenable <= be;
      avsWrite <= w;
      avsRead <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      rdv = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      if (avsWaitrequest !== 1'b0) begin
         fails++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, {24'h0, d}, 4'h1);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 32'h0, 4'hf);
      chk(rdv, {24'h0, e});
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         rc(8'(32 * p + 4), 8'h00);
         rc(8'(32 * p + 8), 8'h00);
         rc(8'(32 * p), extVal[8 * p +: 8]);
         wr(8'(32 * p + 8), 8'haa);
         wr(8'(32 * p + 4), 8'(8'hf0 + p));
         rc(8'(32 * p + 4), 8'(8'hf0 + p));
      end
      repeat (2) @(posedge clk);
      chk({padOe_n, pullupEn}, {24'h0d0e0f, 24'h080a0a});
      chk(padOut & ~padOe_n, 48'ha2a0a0);
      wr(8'h14, 8'h50);
      @(posedge clk);
      rc(8'h00, 8'hf1);
      wr(8'h00, 8'h81);
      wr(8'h00, 8'h00);
      rc(8'h08, 8'h7b);
      wr(8'h0c, 8'h01);
      wr(8'h10, 8'h80);
      wr(8'h18, 8'h02);
      rc(8'h04, 8'h71);
      rc(8'h08, 8'h79);
      rc(8'h0c, 8'h00);
      rc(8'h24, 8'hf1);
      wr(8'h80, 8'h10);
      rc(8'h80, 8'h10);
      chk(pullupEn, 48'h0);
      wr(8'h80, 8'h00);
      repeat (2) @(posedge clk);
      chk(pullupEn, 48'h080a08);
      extEn <= 24'hfffff7;
      rc(8'h00, 8'hf9);
      wr(8'h64, 8'hff);
      rc(8'h64, 8'h00);
      rc(8'h84, 8'h00);
      acc(1'b1, 8'h44, 32'hff, 4'he);
      rc(8'h44, 8'hf2);
      altOwn <= 24'h000080;
      altDrive <= 24'h000080;
      altValue <= 24'h000080;
      repeat (3) @(posedge clk);
      chk({padOe_n, padOut & ~padOe_n}, {24'h0d0e0e, 24'ha2a0f1});
      rst_n <= 1'b0;
      @(negedge clk);
      chk({padOe_n, pullupEn}, {24'hffffff, 24'h0});
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rc(8'h04, 8'h00);
      rc(8'h80, 8'h00);
      results();
   end
endmodule // tb_top
